/* inc/esa_defines.svh */
// register map, field positions and reset values of the e1 spare-bit block
// assumes an 8-bit host port with byte addresses as printed
`ifndef ESA_DEFINES_SVH
`define ESA_DEFINES_SVH

`define ESA_OFS_TX_SI_ALIGN     8'h42
`define ESA_OFS_TX_SI_NONALIGN  8'h43
`define ESA_OFS_TX_ALARM        8'h44
`define ESA_OFS_TX_SPARE4       8'h45
`define ESA_OFS_TX_SPARE5       8'h46
`define ESA_OFS_TX_SPARE6       8'h47
`define ESA_OFS_TX_SPARE7       8'h48
`define ESA_OFS_TX_SPARE8       8'h49
`define ESA_OFS_TX_INSERT_CTRL  8'h4A
`define ESA_OFS_RX_SPARE6       8'h5D
`define ESA_OFS_RX_SPARE7       8'h5E
`define ESA_OFS_RX_SPARE8       8'h5F

`define ESA_RST_BYTE            8'h00

// insertion control bits; bits 0..5 are also the bit positions in a non-align ts0 byte, whose si bit sits at bit 7
`define ESA_BIT_SPARE8          0
`define ESA_BIT_SPARE7          1
`define ESA_BIT_SPARE6          2
`define ESA_BIT_SPARE5          3
`define ESA_BIT_SPARE4          4
`define ESA_BIT_ALARM           5
`define ESA_BIT_SI_NONALIGN     6
`define ESA_BIT_SI_ALIGN        7
// position of the si bit inside any ts0 byte
`define ESA_BIT_SI              7

`define ESA_LAST_FRAME          4'hF

`endif

/* inc/esa_pkg.sv */
// types shared by the e1 spare-bit multiframe access block
// assumes esa_defines.svh for numeric constants
package esa_pkg;

    // one timeslot-0 byte of the framer datapath with its frame number
    typedef struct packed {
        logic       valid;
        logic [3:0] frame;
        logic [7:0] data;
    } esa_ts0_t;

    // host port request
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } esa_host_req_t;

endpackage

/* design/esa_top.sv */
// e1 spare/si bit access per crc4 multiframe: host registers, receive
// capture of sa6..sa8 and transmit insertion into timeslot 0
// assumes framer strobes and host port are synchronous to clk_sys_i
//
// Summary of operation
// [RULE1] three read registers hold received sa6/sa7/sa8, frame 1 in bit 7
// [RULE2] receive sa7 register: frame 15 in bit 0, frame 1 in bit 7
// [RULE3] receive sa8 register: frame 15 in bit 0, frame 1 in bit 7
// [RULE4] transmit align si register feeds even frames, frame 0 in bit 7
// [RULE5] transmit non-align si register feeds odd frames, frame 1 in bit 7
// [RULE6] transmit alarm register feeds a bit of odd frames, frame 1 bit 7
// [RULE7] five transmit registers feed sa4..sa8 of odd frames
// [RULE8] control bit 0 set inserts the transmit sa8 register
// [RULE9] control bit 1 set inserts the transmit sa7 register
// [RULE10] control bit 2 set inserts the transmit sa6 register
// [RULE11] control bit 3 set inserts the transmit sa5 register
// [RULE12] control bit 4 set inserts the transmit sa4 register
// [RULE13] control bit 5 set inserts the alarm register into a bits
// [RULE14] control bit 6 set inserts the non-align si register
// [RULE15] control bit 7 set inserts the align si register
// [RULE16] receive registers refresh once per multiframe and raise a flag
// [RULE17] host reads receive registers within 2 ms of the flag
// [RULE18] transmit registers sampled when transmit flag sets; host updates
// [RULE19] register msb is the first bit received or sent
// [RULE20] with a control bit clear the normal transmit bit passes unchanged
`timescale 1ns/100ps
`default_nettype none
`include "esa_defines.svh"

module esa_top (
    input  wire logic             clk_sys_i,
    input  wire logic             resetn_i,
    input  wire esa_pkg::esa_host_req_t host_req_i,
    output logic [7:0]            host_rdata_o,
    output logic                  host_rvalid_o,
    input  wire esa_pkg::esa_ts0_t rx_ts0_i,
    input  wire esa_pkg::esa_ts0_t tx_ts0_i,
    output esa_pkg::esa_ts0_t     tx_ts0_o,
    input  wire logic             rx_flag_clr_i,
    input  wire logic             tx_flag_clr_i,
    output logic                  rx_multiframe_flag_o,
    output logic                  tx_multiframe_flag_o
);

    // register bit that belongs to a frame: odd/even pairs share an index
    // and the first frame of the multiframe sits in the msb
    function automatic logic frame_bit(input logic [7:0] reg_val,
                                       input logic [3:0] frame);
        logic [2:0] idx;
        idx = 3'h7 - frame[3:1];
        frame_bit = reg_val[idx];
    endfunction

    // place a captured bit at its frame position, keep the rest
    function automatic logic [7:0] put_bit(input logic [7:0] reg_val,
                                           input logic [3:0] frame,
                                           input logic       b);
        logic [2:0] idx;
        logic [7:0] res;
        idx = 3'h7 - frame[3:1];
        res = reg_val;
        res[idx] = b;
        put_bit = res;
    endfunction

    // host-visible transmit registers
    logic [7:0] tx_si_align_bits_r;
    logic [7:0] tx_si_nonalign_bits_r;
    logic [7:0] tx_remote_alarm_bits_r;
    logic [7:0] tx_spare4_bits_r;
    logic [7:0] tx_spare5_bits_r;
    logic [7:0] tx_spare6_bits_r;
    logic [7:0] tx_spare7_bits_r;
    logic [7:0] tx_spare8_bits_r;
    logic [7:0] tx_spare_insert_ctrl_r;

    // copies taken at the multiframe boundary and used while sending
    logic [7:0] sh_si_align_r;
    logic [7:0] sh_si_nonalign_r;
    logic [7:0] sh_alarm_r;
    logic [7:0] sh_spare4_r;
    logic [7:0] sh_spare5_r;
    logic [7:0] sh_spare6_r;
    logic [7:0] sh_spare7_r;
    logic [7:0] sh_spare8_r;

    // receive accumulation and host-visible receive registers
    logic [7:0] acc_spare6_r;
    logic [7:0] acc_spare7_r;
    logic [7:0] acc_spare8_r;
    logic [7:0] rx_spare6_bits_r;
    logic [7:0] rx_spare7_bits_r;
    logic [7:0] rx_spare8_bits_r;

    logic [7:0] rdata_nxt;
    logic [7:0] tx_byte_nxt;
    logic       rx_mf_end;
    logic       tx_mf_end;

    assign rx_mf_end = rx_ts0_i.valid && (rx_ts0_i.frame == `ESA_LAST_FRAME);
    assign tx_mf_end = tx_ts0_i.valid && (tx_ts0_i.frame == `ESA_LAST_FRAME);

    // host writes to transmit registers; receive registers ignore writes
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_si_align_bits_r     <= `ESA_RST_BYTE;
            tx_si_nonalign_bits_r  <= `ESA_RST_BYTE;
            tx_remote_alarm_bits_r <= `ESA_RST_BYTE;
            tx_spare4_bits_r       <= `ESA_RST_BYTE;
            tx_spare5_bits_r       <= `ESA_RST_BYTE;
            tx_spare6_bits_r       <= `ESA_RST_BYTE;
            tx_spare7_bits_r       <= `ESA_RST_BYTE;
            tx_spare8_bits_r       <= `ESA_RST_BYTE;
            tx_spare_insert_ctrl_r <= `ESA_RST_BYTE;
        end else if (host_req_i.wr) begin
            case (host_req_i.addr)
                `ESA_OFS_TX_SI_ALIGN: begin
                    tx_si_align_bits_r <= host_req_i.wdata;
                end
                `ESA_OFS_TX_SI_NONALIGN: begin
                    tx_si_nonalign_bits_r <= host_req_i.wdata;
                end
                `ESA_OFS_TX_ALARM: begin
                    tx_remote_alarm_bits_r <= host_req_i.wdata;
                end
                `ESA_OFS_TX_SPARE4: begin
                    tx_spare4_bits_r <= host_req_i.wdata;
                end
                `ESA_OFS_TX_SPARE5: begin
                    tx_spare5_bits_r <= host_req_i.wdata;
                end
                `ESA_OFS_TX_SPARE6: begin
                    tx_spare6_bits_r <= host_req_i.wdata;
                end
                `ESA_OFS_TX_SPARE7: begin
                    tx_spare7_bits_r <= host_req_i.wdata;
                end
                `ESA_OFS_TX_SPARE8: begin
                    tx_spare8_bits_r <= host_req_i.wdata;
                end
                `ESA_OFS_TX_INSERT_CTRL: begin
                    tx_spare_insert_ctrl_r <= host_req_i.wdata;
                end
                default: begin
                end
            endcase
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        case (host_req_i.addr)
            `ESA_OFS_TX_SI_ALIGN:    rdata_nxt = tx_si_align_bits_r;
            `ESA_OFS_TX_SI_NONALIGN: rdata_nxt = tx_si_nonalign_bits_r;
            `ESA_OFS_TX_ALARM:       rdata_nxt = tx_remote_alarm_bits_r;
            `ESA_OFS_TX_SPARE4:      rdata_nxt = tx_spare4_bits_r;
            `ESA_OFS_TX_SPARE5:      rdata_nxt = tx_spare5_bits_r;
            `ESA_OFS_TX_SPARE6:      rdata_nxt = tx_spare6_bits_r;
            `ESA_OFS_TX_SPARE7:      rdata_nxt = tx_spare7_bits_r;
            `ESA_OFS_TX_SPARE8:      rdata_nxt = tx_spare8_bits_r;
            `ESA_OFS_TX_INSERT_CTRL: rdata_nxt = tx_spare_insert_ctrl_r;
            `ESA_OFS_RX_SPARE6:      rdata_nxt = rx_spare6_bits_r; // [RULE1]
            `ESA_OFS_RX_SPARE7:      rdata_nxt = rx_spare7_bits_r; // [RULE2]
            `ESA_OFS_RX_SPARE8:      rdata_nxt = rx_spare8_bits_r; // [RULE3]
            default:                 rdata_nxt = `ESA_RST_BYTE;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_rdata_o  <= `ESA_RST_BYTE;
            host_rvalid_o <= 1'b0;
        end else begin
            host_rvalid_o <= host_req_i.rd;
            if (host_req_i.rd) begin
                host_rdata_o <= rdata_nxt;
            end
        end
    end

    // receive: collect odd-frame spare bits into the accumulator
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_spare6_r <= `ESA_RST_BYTE;
            acc_spare7_r <= `ESA_RST_BYTE;
            acc_spare8_r <= `ESA_RST_BYTE;
        end else if (rx_ts0_i.valid && rx_ts0_i.frame[0]) begin
            acc_spare6_r <= put_bit(acc_spare6_r, rx_ts0_i.frame,
                rx_ts0_i.data[`ESA_BIT_SPARE6]); // [RULE1] [RULE19]
            acc_spare7_r <= put_bit(acc_spare7_r, rx_ts0_i.frame,
                rx_ts0_i.data[`ESA_BIT_SPARE7]); // [RULE2]
            acc_spare8_r <= put_bit(acc_spare8_r, rx_ts0_i.frame,
                rx_ts0_i.data[`ESA_BIT_SPARE8]); // [RULE3]
        end
    end

    // receive: publish once per multiframe, after frame 15 is in; the
    // previous contents are overwritten, so a slow host loses them
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_spare6_bits_r <= `ESA_RST_BYTE;
            rx_spare7_bits_r <= `ESA_RST_BYTE;
            rx_spare8_bits_r <= `ESA_RST_BYTE;
        end else if (rx_mf_end) begin
            rx_spare6_bits_r <= put_bit(acc_spare6_r, rx_ts0_i.frame,
                rx_ts0_i.data[`ESA_BIT_SPARE6]); // [RULE16]
            rx_spare7_bits_r <= put_bit(acc_spare7_r, rx_ts0_i.frame,
                rx_ts0_i.data[`ESA_BIT_SPARE7]); // [RULE16]
            rx_spare8_bits_r <= put_bit(acc_spare8_r, rx_ts0_i.frame,
                rx_ts0_i.data[`ESA_BIT_SPARE8]); // [RULE16]
        end
    end

    // sticky multiframe flags; a new boundary wins over a clear
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_multiframe_flag_o <= 1'b0;
        end else if (rx_mf_end) begin
            rx_multiframe_flag_o <= 1'b1; // [RULE16]
        end else if (rx_flag_clr_i) begin
            rx_multiframe_flag_o <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_multiframe_flag_o <= 1'b0;
        end else if (tx_mf_end) begin
            tx_multiframe_flag_o <= 1'b1; // [RULE18]
        end else if (tx_flag_clr_i) begin
            tx_multiframe_flag_o <= 1'b0;
        end
    end

    // transmit: sample the eight host data registers for the next multiframe as the flag
    // sets; a data update later than that waits a whole multiframe, control acts at once
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sh_si_align_r    <= `ESA_RST_BYTE;
            sh_si_nonalign_r <= `ESA_RST_BYTE;
            sh_alarm_r       <= `ESA_RST_BYTE;
            sh_spare4_r      <= `ESA_RST_BYTE;
            sh_spare5_r      <= `ESA_RST_BYTE;
            sh_spare6_r      <= `ESA_RST_BYTE;
            sh_spare7_r      <= `ESA_RST_BYTE;
            sh_spare8_r      <= `ESA_RST_BYTE;
        end else if (tx_mf_end) begin
            sh_si_align_r    <= tx_si_align_bits_r; // [RULE18]
            sh_si_nonalign_r <= tx_si_nonalign_bits_r;
            sh_alarm_r       <= tx_remote_alarm_bits_r;
            sh_spare4_r      <= tx_spare4_bits_r;
            sh_spare5_r      <= tx_spare5_bits_r;
            sh_spare6_r      <= tx_spare6_bits_r;
            sh_spare7_r      <= tx_spare7_bits_r;
            sh_spare8_r      <= tx_spare8_bits_r;
        end
    end

    // transmit: overwrite only the enabled positions of timeslot 0
    always_comb begin
        tx_byte_nxt = tx_ts0_i.data; // [RULE20]
        if (!tx_ts0_i.frame[0]) begin
            if (tx_spare_insert_ctrl_r[`ESA_BIT_SI_ALIGN]) begin
                tx_byte_nxt[`ESA_BIT_SI] =
                    frame_bit(sh_si_align_r, tx_ts0_i.frame); // [RULE4] [RULE15]
            end
        end else begin
            if (tx_spare_insert_ctrl_r[`ESA_BIT_SI_NONALIGN]) begin
                tx_byte_nxt[`ESA_BIT_SI] =
                    frame_bit(sh_si_nonalign_r, tx_ts0_i.frame); // [RULE5] [RULE14]
            end
            if (tx_spare_insert_ctrl_r[`ESA_BIT_ALARM]) begin
                tx_byte_nxt[`ESA_BIT_ALARM] =
                    frame_bit(sh_alarm_r, tx_ts0_i.frame); // [RULE6] [RULE13]
            end
            if (tx_spare_insert_ctrl_r[`ESA_BIT_SPARE4]) begin
                tx_byte_nxt[`ESA_BIT_SPARE4] =
                    frame_bit(sh_spare4_r, tx_ts0_i.frame); // [RULE7] [RULE12]
            end
            if (tx_spare_insert_ctrl_r[`ESA_BIT_SPARE5]) begin
                tx_byte_nxt[`ESA_BIT_SPARE5] =
                    frame_bit(sh_spare5_r, tx_ts0_i.frame); // [RULE7] [RULE11]
            end
            if (tx_spare_insert_ctrl_r[`ESA_BIT_SPARE6]) begin
                tx_byte_nxt[`ESA_BIT_SPARE6] =
                    frame_bit(sh_spare6_r, tx_ts0_i.frame); // [RULE7] [RULE10]
            end
            if (tx_spare_insert_ctrl_r[`ESA_BIT_SPARE7]) begin
                tx_byte_nxt[`ESA_BIT_SPARE7] =
                    frame_bit(sh_spare7_r, tx_ts0_i.frame); // [RULE7] [RULE9]
            end
            if (tx_spare_insert_ctrl_r[`ESA_BIT_SPARE8]) begin
                tx_byte_nxt[`ESA_BIT_SPARE8] =
                    frame_bit(sh_spare8_r, tx_ts0_i.frame); // [RULE7] [RULE8]
            end
        end
    end

    // one cycle of latency keeps the output straight from flip-flops
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_ts0_o <= '0;
        end else begin
            tx_ts0_o.valid <= tx_ts0_i.valid;
            tx_ts0_o.frame <= tx_ts0_i.frame;
            tx_ts0_o.data  <= tx_byte_nxt; // [RULE19]
        end
    end

endmodule
`default_nettype wire

/* tb/esa_checker.sv */
// checker: host port, flags and transmit pass-through of esa_top
// assumes it is bound to esa_top and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module esa_checker (
    input wire logic                   clk_sys_i,
    input wire logic                   resetn_i,
    input wire esa_pkg::esa_host_req_t host_req_i,
    input wire logic [7:0]             host_rdata_o,
    input wire logic                   host_rvalid_o,
    input wire esa_pkg::esa_ts0_t      rx_ts0_i,
    input wire esa_pkg::esa_ts0_t      tx_ts0_i,
    input wire esa_pkg::esa_ts0_t      tx_ts0_o,
    input wire logic                   rx_flag_clr_i,
    input wire logic                   tx_flag_clr_i,
    input wire logic                   rx_multiframe_flag_o,
    input wire logic                   tx_multiframe_flag_o
);
    logic [7:0] ctrl_r;
    logic       rx_end;
    logic       tx_end;
    logic       tx_go;
    assign rx_end = rx_ts0_i.valid && rx_ts0_i.frame == 4'hF;
    assign tx_end = tx_ts0_i.valid && tx_ts0_i.frame == 4'hF;
    // writes in the same cycle are left out: their timing is the design's
    assign tx_go = tx_ts0_i.valid && !host_req_i.wr;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl_r <= 8'h00;
        end else if (host_req_i.wr && host_req_i.addr == 8'h4A) begin
            ctrl_r <= host_req_i.wdata;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    a_read_answered: assert property (
        host_req_i.rd |=> host_rvalid_o)
        else $error("read not answered in one cycle");
    a_rvalid_cause: assert property (
        host_rvalid_o |-> $past(host_req_i.rd))
        else $error("read answer without request");
    a_unmapped_zero: assert property (
        host_req_i.rd && host_req_i.addr == 8'h50 |=> host_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (
        !host_req_i.rd |=> $stable(host_rdata_o))
        else $error("read data moved without read");
    a_tx_follow: assert property (
        tx_ts0_i.valid |=> tx_ts0_o.valid
        && tx_ts0_o.frame == $past(tx_ts0_i.frame))
        else $error("transmit byte not passed in one cycle");
    a_tx_plain: assert property (
        tx_go && ctrl_r == 8'h00 |=> tx_ts0_o.data == $past(tx_ts0_i.data))
        else $error("byte changed with insertion off");
    a_even_plain: assert property (
        tx_go && !tx_ts0_i.frame[0] && !ctrl_r[7]
        |=> tx_ts0_o.data == $past(tx_ts0_i.data))
        else $error("align byte changed with si insertion off");
    a_bit6_plain: assert property (
        tx_ts0_i.valid && tx_ts0_i.frame[0]
        |=> tx_ts0_o.data[6] == $past(tx_ts0_i.data[6]))
        else $error("non-align bit 6 changed");
    a_rx_flag_set: assert property (
        rx_end |=> rx_multiframe_flag_o)
        else $error("receive flag not set at frame 15");
    a_rx_flag_clr: assert property (
        rx_flag_clr_i && !rx_end |=> !rx_multiframe_flag_o)
        else $error("receive flag not cleared");
    a_tx_flag_set: assert property (
        tx_end |=> tx_multiframe_flag_o)
        else $error("transmit flag not set at frame 15");
    a_tx_flag_hold: assert property (
        tx_multiframe_flag_o && !tx_flag_clr_i |=> tx_multiframe_flag_o)
        else $error("transmit flag dropped");
    a_tx_flag_cause: assert property (
        $rose(tx_multiframe_flag_o) |-> $past(tx_end))
        else $error("transmit flag without frame 15");
    c_rx_end: cover property (rx_end);
    c_tx_full: cover property (tx_end && ctrl_r == 8'hFF);
    c_rx_read: cover property (host_req_i.rd && host_req_i.addr == 8'h5E);
endmodule
bind esa_top esa_checker esa_checker_inst (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .host_req_i(host_req_i),
    .host_rdata_o(host_rdata_o),
    .host_rvalid_o(host_rvalid_o),
    .rx_ts0_i(rx_ts0_i),
    .tx_ts0_i(tx_ts0_i),
    .tx_ts0_o(tx_ts0_o),
    .rx_flag_clr_i(rx_flag_clr_i),
    .tx_flag_clr_i(tx_flag_clr_i),
    .rx_multiframe_flag_o(rx_multiframe_flag_o),
    .tx_multiframe_flag_o(tx_multiframe_flag_o)
);
`default_nettype wire

/* tb/esa_framer_model.sv */
// framer datapath model: one multiframe of ts0 bytes on both streams
// assumes callers enter run_mf just after a rising clock edge
`timescale 1ns/100ps
`default_nettype none
module esa_framer_model (
    input  wire logic         clk_sys_i,
    output esa_pkg::esa_ts0_t rx_ts0_o,
    output esa_pkg::esa_ts0_t tx_ts0_o
);
    initial begin
        rx_ts0_o = '0;
        tx_ts0_o = '0;
    end
    // idle bytes are inverted so stale data never looks like a frame
    task automatic run_mf(input logic [15:0][7:0] rp, input logic [7:0] bg);
        for (int f = 0; f < 16; f++) begin
            rx_ts0_o = '{1'b1, 4'(f), rp[f]};
            tx_ts0_o = '{1'b1, 4'(f), bg ^ {2{4'(f)}}};
            @(posedge clk_sys_i);
            #1 rx_ts0_o = '{1'b0, 4'(f), ~rp[f]};
            tx_ts0_o.valid = 1'b0;
            tx_ts0_o.data = ~tx_ts0_o.data;
            repeat (2) @(posedge clk_sys_i);
            #1;
        end
    endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// bench: host register access, receive capture and transmit insertion
// assumes esa_top, esa_framer_model and the bound checker are compiled
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    n_errors++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
    logic                   clk_sys_i;
    logic                   resetn_i;
    esa_pkg::esa_host_req_t host_req;
    logic [7:0]             rdata;
    logic                   rvalid;
    esa_pkg::esa_ts0_t      rx_ts0;
    esa_pkg::esa_ts0_t      tx_in;
    esa_pkg::esa_ts0_t      tx_out;
    logic                   rx_clr;
    logic                   tx_clr;
    logic                   rx_flag;
    logic                   tx_flag;
    int                     n_errors = 0;
    int                     cmp_count = 0;
    int                     cyc = 0;
    logic [7:0]             sh [8];
    logic [7:0]             cp [8];
    logic [7:0]             ctrl;
    logic [7:0]             bg;
    logic [3:0]             fexp;
    logic [15:0][7:0]       rp;
    logic [7:0]             tbl [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10,
                                         8'h20, 8'h40, 8'h80, 8'hFF, 8'hFF};
    esa_top esa_top_inst (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .host_req_i(host_req),
        .host_rdata_o(rdata),
        .host_rvalid_o(rvalid),
        .rx_ts0_i(rx_ts0),
        .tx_ts0_i(tx_in),
        .tx_ts0_o(tx_out),
        .rx_flag_clr_i(rx_clr),
        .tx_flag_clr_i(tx_clr),
        .rx_multiframe_flag_o(rx_flag),
        .tx_multiframe_flag_o(tx_flag)
    );
    esa_framer_model esa_framer_model_inst (
        .clk_sys_i(clk_sys_i),
        .rx_ts0_o(rx_ts0),
        .tx_ts0_o(tx_in)
    );
    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [7:0] tx_exp(input logic [3:0] f,
                                          input logic [7:0] d);
        logic [7:0] r;
        r = d;
        if (!f[0]) begin
            if (ctrl[7]) r[7] = cp[0][7 - f[3:1]];
        end else begin
            for (int b = 0; b < 8; b++)
                if (b != 6 && ctrl[b == 7 ? 6 : b])
                    r[b] = cp[b == 7 ? 1 : 7 - b][7 - f[3:1]];
        end
        return r;
    endfunction
    // copies move only after frame 15 has gone out with the old ones
    always @(posedge clk_sys_i) begin
        if (tx_out.valid === 1'b1) begin
            // frame number kept here, not taken from the output
            `CHK(tx_out.frame, fexp)
            `CHK(tx_out.data, tx_exp(fexp, bg ^ {2{fexp}}))
            if (fexp == 4'hF) cp = sh;
            fexp = fexp + 4'h1;
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host_req = '{1'b1, 1'b0, a, d};
        if (a >= 8'h42 && a <= 8'h49) sh[a - 8'h42] = d;
        if (a == 8'h4A) ctrl = d;
        @(posedge clk_sys_i);
        #1 host_req = '0;
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host_req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk_sys_i);
        #1 host_req = '0;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, e)
        @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk_rx();
        logic [7:0] e [3];
        for (int f = 1; f < 16; f += 2)
            for (int k = 0; k < 3; k++) e[k][7 - f / 2] = rp[f][2 - k];
        `CHK(rx_flag, 1'b1)
        `CHK(tx_flag, 1'b1)
        rd_chk(8'h5D, e[0]);
        rd_chk(8'h5E, e[1]);
        rd_chk(8'h5F, e[2]);
        rx_clr = 1'b1;
        tx_clr = 1'b1;
        @(posedge clk_sys_i);
        #1 rx_clr = 1'b0;
        tx_clr = 1'b0;
        `CHK(rx_flag, 1'b0)
        `CHK(tx_flag, 1'b0)
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    initial begin
        resetn_i = 1'b0;
        host_req = '0;
        rx_clr = 1'b0;
        tx_clr = 1'b0;
        ctrl = 8'h00;
        bg = 8'h5A;
        sh = '{default: 8'h00};
        cp = '{default: 8'h00};
        fexp = 4'h0;
        repeat (4) @(posedge clk_sys_i);
        #1 resetn_i = 1'b1;
        for (int a = 8'h40; a < 8'h62; a++) rd_chk(8'(a), 8'h00);
        for (int i = 0; i < 9; i++) wr(8'(8'h42 + i), 8'(8'hA5 ^ (i * 29)));
        for (int i = 0; i < 9; i++)
            rd_chk(8'(8'h42 + i), 8'(8'hA5 ^ (i * 29)));
        wr(8'h5D, 8'hFF);
        rd_chk(8'h5D, 8'h00);
        wr(8'h4A, 8'h00);
        for (int f = 0; f < 16; f++) rp[f] = 8'(f * 53 + 28);
        esa_framer_model_inst.run_mf(rp, bg);
        chk_rx();
        for (int i = 0; i < 10; i++) begin
            if (i == 8)
                for (int j = 0; j < 8; j++) wr(8'(8'h42 + j), ~sh[j]);
            wr(8'h4A, tbl[i]);
            rp[i] = ~rp[i];
            bg = 8'(bg + 8'h11);
            esa_framer_model_inst.run_mf(rp, bg);
        end
        chk_rx();
        tally_and_finish();
    end
endmodule
`default_nettype wire
